/* File: src/hdcb_consts.vh */
// Constants for the haptic driver configuration bank.
// Assumes a 125 MHz system clock and an external I2C target front end.
// Notes on behaviour
// R1 - Pointer upper register keeps four address bits; bits 7:4 read zero.
// R2 - Pointer lower register holds eight address bits, reset zero.
// R3 - Data port access uses memory at pointer, then pointer increments.
// R4 - System control bit 7 selects software or hardware supply adjustment.
// R5 - System control bit 3 gates the digital clock; reset zero.
// R6 - System control bit 2 enables the FIR filter; reset one.
// R7 - Writing one to power bit 7 forces active state.
// R8 - Writing one to power bit 6 forces standby state.
// R9 - Rate field: 00 is 24kHz, 01 is 48kHz, others 12kHz.
// R10 - Gain code maps to 1,2,4,5,8,10,20,40; reset code 4.
// R11 - Output protection pulls drives low after high level for set time.
// R12 - Output protection time counts seven bits of 1/3000 s, reset 0x20.
// R13 - Modulation bit 4 selects half wave or full wave.
// R14 - Input protection pulls drives low after threshold held for set time.
// R15 - Threshold is seven bits in 128ths of supply, reset 0x3F.
// R16 - Input protection time counts eight bits of 1/3000 s, reset 0x32.
// R17 - Diagnostic bit 4 selects resistance measurement or disabled.
// R18 - Converter clock is 12MHz shifted right by code; reset code 2.
// R19 - Setting start bit 0 runs the selected diagnostic.
// R20 - Reserved bits are written and read back like other bits, except pointer upper bits 7:4 and start bits 7:1, which read zero; none has a functional effect.
`ifndef HDCB_CONSTS_VH
`define HDCB_CONSTS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define HDCB_A_PTR_HI    8'h40
`define HDCB_A_PTR_LO    8'h41
`define HDCB_A_DATA      8'h42
`define HDCB_A_SYS1      8'h43
`define HDCB_A_PWR       8'h44
`define HDCB_A_GAIN      8'h49
`define HDCB_A_OPROT     8'h4C
`define HDCB_A_MOD       8'h4D
`define HDCB_A_IPROT     8'h4E
`define HDCB_A_ITIME     8'h4F
`define HDCB_A_DIAG      8'h51
`define HDCB_A_DIAGNOSTIC_START   8'h52

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define HDCB_RST_SYS1    8'h04
`define HDCB_RST_PWR     8'h28
`define HDCB_RST_GAIN    8'h14
`define HDCB_RST_OPROT   8'hA0
`define HDCB_RST_MOD     8'h28
`define HDCB_RST_IPROT   8'hBF
`define HDCB_RST_ITIME   8'h32
`define HDCB_RST_DIAG    8'h02

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define HDCB_B_VMODE     7
`define HDCB_B_CLKGATE   3
`define HDCB_B_FIR       2
`define HDCB_B_WAKE      7
`define HDCB_B_STBY      6
`define HDCB_B_PROT_EN   7
`define HDCB_B_FULLWAVE  4
`define HDCB_B_RL_SEL    4
`define HDCB_B_GO        0
`define HDCB_PTR_HI_MSK  8'h0F
`define HDCB_OUT_THR     7'h7C

// ---------------------------------------------------------------
// Timing: protection unit is 1/3000 s
// ---------------------------------------------------------------
`define HDCB_CLK_HZ      125000000
`define HDCB_UNIT_HZ     3000
`define HDCB_UNIT_CYC    (`HDCB_CLK_HZ / `HDCB_UNIT_HZ)
`define HDCB_PRE_W       16
`define HDCB_ADC_BASE_HZ 12000000
`define HDCB_DIAG_CYC    16'h0100
// Base clock and system clock in MHz, for the phase accumulator
`define HDCB_NCO_STEP    7'h0C
`define HDCB_NCO_MOD     7'h7D

`endif

/* File: src/hdcb_prot_timer.v */
// Persistence timer for one drive-output protection path.
// Assumes a shared 1/3000 s tick enable from the bank.
`include "hdcb_consts.vh"

module hdcb_prot_timer (
   // Clock and reset
   input  wire       sys_clk,
   input  wire       arst_n,
   // Control
   input  wire       tick,
   input  wire       enable,
   input  wire       over,
   input  wire [7:0] limit,
   // Result
   output reg        trip_r
);
   reg [7:0] cnt_r;

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r  <= 8'h00;
         trip_r <= 1'b0;
      end else if (!enable || !over) begin
         cnt_r  <= 8'h00;
         trip_r <= 1'b0;
      end else if (tick && !trip_r) begin
         if (cnt_r >= limit)
            trip_r <= 1'b1;
         else
            cnt_r <= cnt_r + 8'h01;
      end
   end
endmodule // hdcb_prot_timer

/* File: src/hdcb_config_bank.v */
// Configuration bank: waveform memory window, system control, protection.
// Assumes an I2C target front end presenting byte reads and writes.
`include "hdcb_consts.vh"

module hdcb_config_bank (
   // Clock and reset
   input  wire       sys_clk,
   input  wire       arst_n,
   // Register access from the I2C front end
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata_r,
   output reg        reg_rvalid_r,
   // Drive path monitor inputs
   input  wire [6:0] out_level_pos,
   input  wire [6:0] out_level_neg,
   input  wire       drive_in_pos,
   input  wire       drive_in_neg,
   // Diagnostic converter done
   input  wire       diag_done,
   // Drive outputs and control levels
   output reg        drive_out_pos,
   output reg        drive_out_neg,
   output reg        supply_hw_adjust_r,
   output reg        digital_clock_gate_r,
   output reg        filter_enable_r,
   output reg        force_active_r,
   output reg        force_standby_r,
   output reg  [1:0] wave_rate_select_r,
   output reg  [5:0] diff_single_gain_r,
   output reg        full_wave_select_r,
   output reg  [2:0] adc_clk_div_r,
   output reg        adc_clk_en_r,
   output reg        diag_busy_r
);
   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   reg [7:0]  wave_mem [0:4095];
   reg [3:0]  mem_ptr_upper_r;
   reg [7:0]  mem_ptr_lower_r;
   reg [7:0]  sys1_r;
   reg [7:0]  pwr_r;
   reg [7:0]  gain_r;
   reg [7:0]  oprot_r;
   reg [7:0]  mod_r;
   reg [7:0]  iprot_r;
   reg [7:0]  itime_r;
   reg [7:0]  diag_r;
   reg [15:0] pre_r;
   reg        tick_r;
   reg [15:0] diag_cnt_r;
   reg [6:0]  adc_cnt_r;
   reg [6:0]  adc_phase_r;
   reg        adc_base_en_r;
   reg [7:0]  rd_nxt;
   wire [11:0] ptr = {mem_ptr_upper_r, mem_ptr_lower_r};
   wire       o_trip;
   wire       i_trip;

   // Gain code to actual gain
   function [5:0] gain_of;
      input [2:0] code;
      begin
         case (code)
            3'h0:    gain_of = 6'h01;
            3'h1:    gain_of = 6'h02;
            3'h2:    gain_of = 6'h04;
            3'h3:    gain_of = 6'h05;
            3'h4:    gain_of = 6'h08;
            3'h5:    gain_of = 6'h0A;
            3'h6:    gain_of = 6'h14;
            default: gain_of = 6'h28;
         endcase
      end
   endfunction

   // Access decode, used by both read and write
   function hit;
      input [7:0] a;
      input [7:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   // ------------------------------------------------------------
   // Register writes and pointer advance
   // ------------------------------------------------------------
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_ptr_upper_r <= 4'h0;                          // R1
         mem_ptr_lower_r <= 8'h00;                         // R2
         sys1_r  <= `HDCB_RST_SYS1;                        // R6
         pwr_r   <= `HDCB_RST_PWR;
         gain_r  <= `HDCB_RST_GAIN;
         oprot_r <= `HDCB_RST_OPROT;                       // R12
         mod_r   <= `HDCB_RST_MOD;
         iprot_r <= `HDCB_RST_IPROT;                       // R15
         itime_r <= `HDCB_RST_ITIME;                       // R16
         diag_r  <= `HDCB_RST_DIAG;
      end else if (reg_wr) begin
         if (hit(reg_addr, `HDCB_A_PTR_HI))
            mem_ptr_upper_r <= reg_wdata[3:0];             // R1
         if (hit(reg_addr, `HDCB_A_PTR_LO))
            mem_ptr_lower_r <= reg_wdata;                  // R2
         if (hit(reg_addr, `HDCB_A_DATA))
            {mem_ptr_upper_r, mem_ptr_lower_r} <= ptr + 12'h001; // R3
         if (hit(reg_addr, `HDCB_A_SYS1))
            sys1_r  <= reg_wdata;
         if (hit(reg_addr, `HDCB_A_PWR))
            pwr_r   <= reg_wdata;
         if (hit(reg_addr, `HDCB_A_GAIN))
            gain_r  <= reg_wdata;
         if (hit(reg_addr, `HDCB_A_OPROT))
            oprot_r <= reg_wdata;
         if (hit(reg_addr, `HDCB_A_MOD))
            mod_r   <= reg_wdata;
         if (hit(reg_addr, `HDCB_A_IPROT))
            iprot_r <= reg_wdata;
         if (hit(reg_addr, `HDCB_A_ITIME))
            itime_r <= reg_wdata;
         if (hit(reg_addr, `HDCB_A_DIAG))
            diag_r  <= reg_wdata;
      end else if (reg_rd && hit(reg_addr, `HDCB_A_DATA)) begin
         {mem_ptr_upper_r, mem_ptr_lower_r} <= ptr + 12'h001; // R3
      end
   end

   // Memory write port, no reset
   always @(posedge sys_clk) begin
      if (reg_wr && hit(reg_addr, `HDCB_A_DATA))
         wave_mem[ptr] <= reg_wdata;                       // R3
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   always @* begin
      rd_nxt = 8'h00;
      case (reg_addr)
         `HDCB_A_PTR_HI: rd_nxt = {4'h0, mem_ptr_upper_r};  // R1
         `HDCB_A_PTR_LO: rd_nxt = mem_ptr_lower_r;
         `HDCB_A_DATA:   rd_nxt = wave_mem[ptr];            // R3
         `HDCB_A_SYS1:   rd_nxt = sys1_r;
         `HDCB_A_PWR:    rd_nxt = pwr_r;
         `HDCB_A_GAIN:   rd_nxt = gain_r;
         `HDCB_A_OPROT:  rd_nxt = oprot_r;
         `HDCB_A_MOD:    rd_nxt = mod_r;
         `HDCB_A_IPROT:  rd_nxt = iprot_r;
         `HDCB_A_ITIME:  rd_nxt = itime_r;
         `HDCB_A_DIAG:   rd_nxt = diag_r;
         `HDCB_A_DIAGNOSTIC_START: rd_nxt = {7'h00, diag_busy_r};
         default:        rd_nxt = 8'h00;
      endcase
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata_r  <= 8'h00;
         reg_rvalid_r <= 1'b0;
      end else begin
         reg_rvalid_r <= reg_rd;
         if (reg_rd)
            reg_rdata_r <= rd_nxt;
      end
   end

   // ------------------------------------------------------------
   // Decoded control levels
   // ------------------------------------------------------------
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         supply_hw_adjust_r   <= 1'b0;
         digital_clock_gate_r <= 1'b0;
         filter_enable_r      <= 1'b1;
         force_active_r       <= 1'b0;
         force_standby_r      <= 1'b0;
         wave_rate_select_r   <= 2'h0;
         diff_single_gain_r   <= 6'h08;
         full_wave_select_r   <= 1'b0;
         adc_clk_div_r        <= 3'h2;
      end else begin
         supply_hw_adjust_r   <= sys1_r[`HDCB_B_VMODE];     // R4
         digital_clock_gate_r <= sys1_r[`HDCB_B_CLKGATE];   // R5
         filter_enable_r      <= sys1_r[`HDCB_B_FIR];       // R6
         force_active_r       <= pwr_r[`HDCB_B_WAKE];       // R7
         force_standby_r      <= pwr_r[`HDCB_B_STBY];       // R8
         // Codes 10 and 11 both mean the 12kHz rate
         wave_rate_select_r   <= pwr_r[1] ? 2'h2 : pwr_r[1:0]; // R9
         diff_single_gain_r   <= gain_of(gain_r[2:0]);      // R10
         full_wave_select_r   <= mod_r[`HDCB_B_FULLWAVE];   // R13
         adc_clk_div_r        <= diag_r[2:0];               // R18 R20
      end
   end

   // ------------------------------------------------------------
   // Protection timers, 1/3000 s tick
   // ------------------------------------------------------------
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pre_r  <= 16'h0000;
         tick_r <= 1'b0;
      end else if (pre_r == `HDCB_UNIT_CYC - 1) begin
         pre_r  <= 16'h0000;
         tick_r <= 1'b1;
      end else begin
         pre_r  <= pre_r + 16'h0001;
         tick_r <= 1'b0;
      end
   end

   hdcb_prot_timer u_out_prot (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .tick    (tick_r),
      .enable  (oprot_r[`HDCB_B_PROT_EN]),                  // R11
      .over    ((out_level_pos >= `HDCB_OUT_THR) ||
                (out_level_neg >= `HDCB_OUT_THR)),          // R11
      .limit   ({1'b0, oprot_r[6:0]}),                      // R12
      .trip_r  (o_trip)
   );

   hdcb_prot_timer u_in_prot (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .tick    (tick_r),
      .enable  (iprot_r[`HDCB_B_PROT_EN]),                  // R14
      .over    ((out_level_pos >= iprot_r[6:0]) ||
                (out_level_neg >= iprot_r[6:0])),           // R15
      .limit   (itime_r),                                   // R16
      .trip_r  (i_trip)
   );

   // Protection forces both outputs low
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         drive_out_pos <= 1'b0;
         drive_out_neg <= 1'b0;
      end else begin
         drive_out_pos <= drive_in_pos && !o_trip && !i_trip; // R11 R14
         drive_out_neg <= drive_in_neg && !o_trip && !i_trip; // R11 R14
      end
   end

   // ------------------------------------------------------------
   // Diagnostic start and converter clock enable
   // ------------------------------------------------------------
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         diag_busy_r <= 1'b0;
         diag_cnt_r  <= 16'h0000;
      end else if (reg_wr && hit(reg_addr, `HDCB_A_DIAGNOSTIC_START) &&
                   reg_wdata[`HDCB_B_GO] &&
                   diag_r[`HDCB_B_RL_SEL]) begin
         diag_busy_r <= 1'b1;                               // R17 R19
         diag_cnt_r  <= 16'h0000;
      end else if (diag_busy_r) begin
         diag_cnt_r <= diag_cnt_r + 16'h0001;
         if (diag_done || diag_cnt_r == `HDCB_DIAG_CYC)
            diag_busy_r <= 1'b0;
      end
   end

   // 12 MHz base enable from a phase accumulator
   // Fractional divide: 12 of every 125 cycles carry a base tick
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         adc_phase_r   <= 7'h00;
         adc_base_en_r <= 1'b0;
      end else if (!diag_busy_r) begin
         adc_phase_r   <= 7'h00;
         adc_base_en_r <= 1'b0;
      end else if (adc_phase_r >= `HDCB_NCO_MOD - `HDCB_NCO_STEP) begin
         adc_phase_r   <= adc_phase_r + `HDCB_NCO_STEP - `HDCB_NCO_MOD; // R18
         adc_base_en_r <= 1'b1;
      end else begin
         adc_phase_r   <= adc_phase_r + `HDCB_NCO_STEP;
         adc_base_en_r <= 1'b0;
      end
   end

   // Converter clock enable every 2^code base ticks while busy
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         adc_cnt_r    <= 7'h00;
         adc_clk_en_r <= 1'b0;
      end else if (!diag_busy_r) begin
         adc_cnt_r    <= 7'h00;
         adc_clk_en_r <= 1'b0;
      end else if (adc_base_en_r) begin
         adc_cnt_r    <= adc_cnt_r + 7'h01;
         adc_clk_en_r <= ((adc_cnt_r & ((7'h01 << adc_clk_div_r) - 7'h01))
                          == 7'h00);                        // R18
      end else begin
         adc_clk_en_r <= 1'b0;
      end
   end
endmodule // hdcb_config_bank

/* File: tb/hdcb_config_bank_properties.sv */
// Port assertions for the configuration bank.
// Bound to hdcb_config_bank; one clock, async low reset.
`include "hdcb_consts.vh"
module hdcb_config_bank_properties (
   // Clock and reset
   input wire logic       sys_clk,
   input wire logic       arst_n,
   // Register access
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata_r,
   input wire logic       reg_rvalid_r,
   // Drive and diagnostic
   input wire logic       drive_in_pos,
   input wire logic       drive_out_pos,
   input wire logic       diag_busy_r,
   // Control levels
   input wire logic       supply_hw_adjust_r,
   input wire logic       digital_clock_gate_r,
   input wire logic       filter_enable_r,
   input wire logic       force_active_r,
   input wire logic       force_standby_r,
   input wire logic [1:0] wave_rate_select_r,
   input wire logic [5:0] diff_single_gain_r,
   input wire logic       full_wave_select_r,
   input wire logic [2:0] adc_clk_div_r
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [5:0] GTAB [8] = '{6'h01, 6'h02, 6'h04, 6'h05,
                                       6'h08, 6'h0A, 6'h14, 6'h28};
   logic w41, w43, w44, w49, w4d, w51, w52;
   logic diag_sel_r;
   assign w41 = reg_wr && reg_addr == `HDCB_A_PTR_LO;
   assign w43 = reg_wr && reg_addr == `HDCB_A_SYS1;
   assign w44 = reg_wr && reg_addr == `HDCB_A_PWR;
   assign w49 = reg_wr && reg_addr == `HDCB_A_GAIN;
   assign w4d = reg_wr && reg_addr == `HDCB_A_MOD;
   assign w51 = reg_wr && reg_addr == `HDCB_A_DIAG;
   assign w52 = reg_wr && reg_addr == `HDCB_A_DIAGNOSTIC_START;
   // Tracks the diagnostic select bit
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) diag_sel_r <= 1'b0;
      else if (w51) diag_sel_r <= reg_wdata[`HDCB_B_RL_SEL];
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   property p_ptr_hi;
      reg_rd && reg_addr == `HDCB_A_PTR_HI |=> reg_rdata_r[7:4] == 4'h0;
   endproperty
   a_ptr_hi: assert property (p_ptr_hi) else $error("pointer top set");
   property p_ptr_lo;
      w41 ##2 (reg_rd && !reg_wr && reg_addr == 8'h41)
         |=> reg_rvalid_r && reg_rdata_r == $past(reg_wdata, 3);
   endproperty
   a_ptr_lo: assert property (p_ptr_lo) else $error("pointer low lost");
   property p_unmapped;
      reg_rd && reg_addr == 8'h60 |=> reg_rvalid_r && reg_rdata_r == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped data");
   property p_sys1;
      w43 ##1 !w43 |=> supply_hw_adjust_r == $past(reg_wdata[7], 2) &&
         digital_clock_gate_r == $past(reg_wdata[3], 2) &&
         filter_enable_r == $past(reg_wdata[2], 2);
   endproperty
   a_sys1: assert property (p_sys1) else $error("control one");
   property p_pwr;
      w44 ##1 !w44 |=> force_active_r == $past(reg_wdata[7], 2) &&
         force_standby_r == $past(reg_wdata[6], 2) &&
         wave_rate_select_r == ($past(reg_wdata[1:0], 2) == 2'h0 ? 2'h0 :
         $past(reg_wdata[1:0], 2) == 2'h1 ? 2'h1 : 2'h2);
   endproperty
   a_pwr: assert property (p_pwr) else $error("power or rate");
   property p_gain;
      w49 ##1 !w49 |=>
         diff_single_gain_r == GTAB[$past(reg_wdata[2:0], 2)];
   endproperty
   a_gain: assert property (p_gain) else $error("gain value");
   property p_mod;
      w4d ##1 !w4d |=> full_wave_select_r == $past(reg_wdata[4], 2);
   endproperty
   a_mod: assert property (p_mod) else $error("modulation");
   property p_div;
      w51 ##1 !w51 |=> adc_clk_div_r == $past(reg_wdata[2:0], 2);
   endproperty
   a_div: assert property (p_div) else $error("converter divider");
   property p_go;
      w52 && reg_wdata[0] && diag_sel_r |-> ##[1:3] diag_busy_r;
   endproperty
   a_go: assert property (p_go) else $error("diagnostic idle");
   property p_drive;
      !drive_in_pos [*2] |-> !drive_out_pos;
   endproperty
   a_drive: assert property (p_drive) else $error("drive unrequested");
   c_read: cover property (reg_rvalid_r);
   c_diag: cover property ($rose(diag_busy_r));
   c_trip: cover property (drive_in_pos && $fell(drive_out_pos));
endmodule // hdcb_config_bank_properties

bind hdcb_config_bank hdcb_config_bank_properties chk_u (
   .sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata_r, .reg_rvalid_r, .drive_in_pos, .drive_out_pos,
   .diag_busy_r, .supply_hw_adjust_r, .digital_clock_gate_r,
   .filter_enable_r, .force_active_r, .force_standby_r,
   .wave_rate_select_r, .diff_single_gain_r, .full_wave_select_r,
   .adc_clk_div_r);

/* File: tb/hdcb_host_model.sv */
// Host side of the register access path.
// Drives on falling edges; idle lines carry inverted last values.
module hdcb_host_model (
   // Clock
   input  wire logic       sys_clk,
   // Register access
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata_r,
   input  wire logic       reg_rvalid_r
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic ok);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      ok = reg_rvalid_r;
      d = reg_rdata_r;
      reg_rd = 1'b0;
      reg_addr = ~a;
   endtask
endmodule // hdcb_host_model

/* File: tb/haptic_driver_config_bank_test.sv */
// Self-checking bench for the configuration bank.
// Register traffic via hdcb_host_model; monitors driven here.
module haptic_driver_config_bank_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic       sys_clk, arst_n, drive_in_pos, drive_in_neg, diag_done;
   logic [6:0] out_level_pos, out_level_neg;
   wire  [7:0] reg_addr, reg_wdata, reg_rdata_r;
   wire        reg_wr, reg_rd, reg_rvalid_r, drive_out_pos, drive_out_neg;
   wire        supply_hw_adjust_r, digital_clock_gate_r, filter_enable_r;
   wire        force_active_r, force_standby_r, full_wave_select_r;
   wire        adc_clk_en_r, diag_busy_r;
   wire  [1:0] wave_rate_select_r;
   wire  [5:0] diff_single_gain_r;
   wire  [2:0] adc_clk_div_r;
   int         fail_count = 0;
   int         n_compared = 0;
   logic [7:0] adr [10] = '{8'h40, 8'h41, 8'h43, 8'h44, 8'h49, 8'h4C,
                            8'h4D, 8'h4E, 8'h4F, 8'h51};
   logic [7:0] rst [10] = '{8'h00, 8'h00, 8'h04, 8'h28, 8'h14, 8'hA0,
                            8'h28, 8'hBF, 8'h32, 8'h02};
   logic [5:0] gtab [8] = '{6'h01, 6'h02, 6'h04, 6'h05,
                            6'h08, 6'h0A, 6'h14, 6'h28};
   hdcb_config_bank dut_u (
      .sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata_r, .reg_rvalid_r, .out_level_pos, .out_level_neg,
      .drive_in_pos, .drive_in_neg, .diag_done, .drive_out_pos,
      .drive_out_neg, .supply_hw_adjust_r, .digital_clock_gate_r,
      .filter_enable_r, .force_active_r, .force_standby_r,
      .wave_rate_select_r, .diff_single_gain_r, .full_wave_select_r,
      .adc_clk_div_r, .adc_clk_en_r, .diag_busy_r);
   hdcb_host_model host_u (
      .sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r,
      .reg_rvalid_r);
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       ok;
      host_u.rd(a, d, ok);
      chk({7'h00, ok}, 8'h01);
      chk(d, exp);
   endtask
   task automatic print_verdict;
      if (fail_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic t_reset;
      chk({2'h0, diff_single_gain_r}, 8'h08);
      chk({4'h0, adc_clk_div_r, filter_enable_r}, 8'h05);
      foreach (adr[i]) rdc(adr[i], rst[i]);
   endtask
   task automatic t_readback;
      foreach (adr[i]) host_u.wr(adr[i], 8'hFF);
      host_u.wr(8'h60, 8'hFF);
      foreach (adr[i]) rdc(adr[i], i == 0 ? 8'h0F : 8'hFF);
      rdc(8'h60, 8'h00);
      chk({supply_hw_adjust_r, digital_clock_gate_r, force_active_r,
           force_standby_r, full_wave_select_r, adc_clk_div_r},
          8'hFF);
      host_u.wr(8'h43, 8'h00);
      host_u.wr(8'h4D, 8'h00);
      @(negedge sys_clk);
      chk({5'h00, filter_enable_r, digital_clock_gate_r,
           full_wave_select_r}, 8'h00);
   endtask
   task automatic t_rate_gain;
      for (int c = 0; c < 8; c++) begin
         host_u.wr(8'h49, {5'h02, c[2:0]});
         host_u.wr(8'h44, {6'h0A, c[1:0]});
         @(negedge sys_clk);
         chk({2'h0, diff_single_gain_r}, {2'h0, gtab[c]});
         chk({6'h00, wave_rate_select_r},
             c[1:0] < 2'h2 ? {6'h00, c[1:0]} : 8'h02);
      end
   endtask
   task automatic t_memory;
      host_u.wr(8'h40, 8'hF1);
      host_u.wr(8'h41, 8'hFF);
      rdc(8'h41, 8'hFF);
      host_u.wr(8'h42, 8'hAB);
      host_u.wr(8'h42, 8'hCD);
      rdc(8'h40, 8'h02);
      rdc(8'h41, 8'h01);
      host_u.wr(8'h40, 8'h01);
      host_u.wr(8'h41, 8'hFF);
      rdc(8'h42, 8'hAB);
      rdc(8'h42, 8'hCD);
      host_u.wr(8'h40, 8'h0F);
      host_u.wr(8'h41, 8'hFF);
      host_u.wr(8'h42, 8'hEE);
      rdc(8'h40, 8'h00);
   endtask
   task automatic t_diag;
      int n;
      host_u.wr(8'h51, 8'h03);
      host_u.wr(8'h52, 8'h01);
      repeat (3) @(negedge sys_clk);
      chk({7'h00, diag_busy_r}, 8'h00);
      host_u.wr(8'h51, 8'h13);
      host_u.wr(8'h52, 8'h01);
      repeat (2) @(negedge sys_clk);
      chk({7'h00, diag_busy_r}, 8'h01);
      n = 0;
      repeat (120) @(negedge sys_clk) n += adc_clk_en_r;
      chk(n[7:0], 8'h02);
      diag_done = 1'b1;
      @(negedge sys_clk);
      diag_done = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk({7'h00, diag_busy_r}, 8'h00);
   endtask
   task automatic t_protect;
      int n;
      host_u.wr(8'h4E, 8'h3F);
      host_u.wr(8'h4C, 8'h80);
      drive_in_pos = 1'b1;
      drive_in_neg = 1'b1;
      out_level_pos = 7'h7B;
      repeat (3) @(negedge sys_clk);
      chk({6'h00, drive_out_pos, drive_out_neg}, 8'h03);
      out_level_pos = 7'h7C;
      n = 0;
      while (drive_out_pos === 1'b1 && n < 45000) begin
         @(negedge sys_clk);
         n++;
      end
      chk({6'h00, drive_out_pos, drive_out_neg}, 8'h00);
      chk({7'h00, n < 41675}, 8'h01);
      out_level_pos = 7'h00;
      repeat (4) @(negedge sys_clk);
      chk({6'h00, drive_out_pos, drive_out_neg}, 8'h03);
      host_u.wr(8'h4C, 8'h00);
      host_u.wr(8'h4F, 8'h00);
      host_u.wr(8'h4E, 8'hC0);
      out_level_neg = 7'h40;
      n = 0;
      while (drive_out_neg === 1'b1 && n < 45000) begin
         @(negedge sys_clk);
         n++;
      end
      chk({6'h00, drive_out_pos, drive_out_neg}, 8'h00);
      chk({7'h00, n < 41675}, 8'h01);
   endtask
   // Cut a hang short
   initial begin
      #760000;
      fail_count++;
      print_verdict;
   end
   initial begin
      arst_n = 1'b0;
      drive_in_pos = 1'b0;
      drive_in_neg = 1'b0;
      diag_done = 1'b0;
      out_level_pos = 7'h00;
      out_level_neg = 7'h00;
      repeat (12) @(negedge sys_clk);
      arst_n = 1'b1;
      t_reset;
      t_readback;
      t_rate_gain;
      t_memory;
      t_diag;
      t_protect;
      print_verdict;
   end
endmodule // haptic_driver_config_bank_test
